// ===== logic/scpcp_pkg.sv
// package of constants and types for the text command parser
package scpcp_pkg;
    // register byte offsets
    localparam logic [3:0] ADDR_RX     = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_COUNT  = 4'h8;
    localparam logic [3:0] ADDR_MASKS  = 4'hC;
    // character codes
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_STAR  = 8'h2A;
    localparam logic [7:0] CH_COLON = 8'h3A;
    localparam logic [7:0] CH_SEMI  = 8'h3B;
    localparam logic [7:0] CH_LF    = 8'h0A;
    localparam logic [7:0] CH_QUERY = 8'h3F;
    // letters of the digital bus trigger source name, first letter in the top byte
    localparam logic [31:0] TXT_DIGITAL_BUS = 32'h4442_5553;
    // status fields
    localparam int OPER_SCAN_BIT = 8;
    localparam int STB_OPER_BIT  = 7;
    localparam int STB_MSS_BIT   = 6;
    localparam logic [15:0] OPER_SCAN_MASK = 16'h0100;
    localparam logic [7:0]  SRE_OPER_MASK  = 8'h80;
    // arm count limits and reset value
    localparam logic [14:0] COUNT_MIN = 15'h0001;
    localparam logic [14:0] COUNT_MAX = 15'h7FFF;
    localparam logic [14:0] COUNT_DEF = 15'h0001;
    localparam int KW_LEN = 12;
    typedef enum logic [2:0] {
        SRC_BUS, SRC_DIGITAL_BUS, SRC_EXT, SRC_HOLD, SRC_IMM
    } scpcp_src_t;
    typedef enum logic [3:0] {
        CMD_NONE, CMD_CLS, CMD_SRE, CMD_ABORT, CMD_INIT, CMD_CONT,
        CMD_COUNT, CMD_COUNT_Q, CMD_TRIG_SRC, CMD_OPER_ENAB, CMD_BAD
    } scpcp_cmd_t;
endpackage

// ===== logic/scpcp_parser.sv
// text command parser with scan status reporting, avalon slave
`timescale 1ns/100ps
module scpcp_parser (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        scan_done_i,
    output logic             scan_run_o,
    output logic             srq_o,
    output scpcp_pkg::scpcp_src_t trig_src_o
);
    import scpcp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // parser state
    logic [7:0]        kw_r [KW_LEN];
    logic [3:0]        kw_len_r;
    logic              in_param_r;
    logic              is_common_r;
    logic [2:0]        path_r;
    logic [7:0]        par_r [KW_LEN];
    logic [3:0]        par_len_r;
    logic              err_r;
    logic              query_r;
    logic              wait_r;
    logic [31:0]       resp_r;
    logic [14:0]       count_r;
    logic              cont_r;
    logic [15:0]       oper_en_r;
    logic [15:0]       oper_ev_r;
    logic [7:0]        sre_r;
    logic              bus_start_r;

    logic [7:0]        ch;
    logic [7:0]        up_kw [KW_LEN];
    logic [7:0]        up_par [KW_LEN];
    assign ch = avs_writedata_i[7:0];

    // upper-case copies of keyword and parameter characters
    // case folded
    genvar gi;
    generate
        for (gi = 0; gi < KW_LEN; gi++) begin : g_up
            assign up_kw[gi]  = (kw_r[gi]  >= 8'h61 && kw_r[gi]  <= 8'h7A) ?
                                kw_r[gi]  - 8'h20 : kw_r[gi];
            assign up_par[gi] = (par_r[gi] >= 8'h61 && par_r[gi] <= 8'h7A) ?
                                par_r[gi] - 8'h20 : par_r[gi];
        end
    endgenerate

    // keyword matcher: short or full form only
    // short or full
    function automatic logic kw_is(input string full, input int short_n,
                                   input logic [3:0] n);
        logic ok;
        ok = (n == 4'(short_n)) || (n == 4'(full.len()));
        for (int i = 0; i < KW_LEN; i++) begin
            if (i < int'(n) && i < full.len() && up_kw[i] != full[i])
                ok = 1'b0;
        end
        return ok;
    endfunction

    function automatic logic par_is(input string s);
        logic ok;
        ok = (par_len_r == 4'(s.len()));
        for (int i = 0; i < KW_LEN; i++) begin
            if (i < s.len() && up_par[i] != s[i])
                ok = 1'b0;
        end
        return ok;
    endfunction

    // decimal number: sign, point, exponent; value truncated to an integer
    // numeric forms
    function automatic logic [15:0] par_num(output logic bad);
        logic [31:0] v;
        logic        frac;
        logic        neg;
        logic        expo;
        logic        eneg;
        logic [3:0]  e;
        logic [3:0]  fd;
        int          sh;
        v = 32'h0000_0000;
        frac = 1'b0;
        neg = 1'b0;
        expo = 1'b0;
        eneg = 1'b0;
        e = 4'h0;
        fd = 4'h0;
        bad = (par_len_r == 4'h0);
        for (int i = 0; i < KW_LEN; i++) begin
            if (i < int'(par_len_r)) begin
                if (up_par[i] == 8'h2D && i == 0) neg = 1'b1;
                else if (up_par[i] == 8'h2B && i == 0) neg = 1'b0;
                else if (up_par[i] == 8'h2E && !expo) frac = 1'b1;
                else if (up_par[i] == 8'h45 && !expo) expo = 1'b1;
                else if (expo && up_par[i] == 8'h2D) eneg = 1'b1;
                else if (expo && up_par[i] == 8'h2B) eneg = 1'b0;
                else if (up_par[i] >= 8'h30 && up_par[i] <= 8'h39) begin
                    if (expo) e = 4'(e * 4'hA + 4'(up_par[i] - 8'h30));
                    else begin
                        // fraction digits are kept and scaled out below
                        v = 32'(v * 32'h0000_000A + 32'(up_par[i] - 8'h30));
                        if (frac) fd = fd + 4'h1;
                    end
                end else bad = 1'b1;
            end
        end
        // net power of ten: exponent less the digits after the point
        sh = (eneg ? -int'(e) : int'(e)) - int'(fd);
        for (int j = 0; j < 27; j++) begin
            if (j < sh) v = 32'(v * 32'h0000_000A);
            else if (j < -sh) v = v / 32'h0000_000A;
        end
        if (neg) bad = 1'b1;
        return v[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode of a finished keyword against the tree
    // path: 0 root, 1 route, 2 status, 3 status:oper, 4 arm, 5 trig, 6 init
    scpcp_cmd_t cmd_sel;
    logic [2:0] path_nxt;
    always_comb begin
        cmd_sel  = CMD_NONE;
        path_nxt = path_r;
        if (is_common_r) begin
            if (kw_len_r == 4'h3 && kw_is("CLS", 3, kw_len_r)) cmd_sel = CMD_CLS;
            else if (kw_len_r == 4'h3 && kw_is("SRE", 3, kw_len_r)) cmd_sel = CMD_SRE;
            else if (kw_len_r == 4'h3 && kw_is("RST", 3, kw_len_r)) cmd_sel = CMD_NONE;
            else cmd_sel = CMD_BAD;
        end else begin
            case (path_r)
                3'd0: begin
                    if (kw_is("ROUTE", 4, kw_len_r)) path_nxt = 3'd1;
                    else if (kw_is("STATUS", 4, kw_len_r)) path_nxt = 3'd2;
                    else if (kw_is("ARM", 3, kw_len_r)) path_nxt = 3'd4;
                    else if (kw_is("TRIGGER", 4, kw_len_r)) path_nxt = 3'd5;
                    else if (kw_is("INITIATE", 4, kw_len_r)) path_nxt = 3'd6;
                    else if (kw_is("ABORT", 4, kw_len_r)) cmd_sel = CMD_ABORT;
                    else if (kw_is("SCAN", 4, kw_len_r)) path_nxt = 3'd1;
                    else cmd_sel = CMD_BAD;
                end
                3'd1: cmd_sel = (kw_is("SCAN", 4, kw_len_r) || kw_is("MODE", 4, kw_len_r)
                                 || kw_is("PORT", 4, kw_len_r)) ? CMD_NONE : CMD_BAD;
                3'd2: if (kw_is("OPERATION", 4, kw_len_r)) path_nxt = 3'd3;
                      else cmd_sel = CMD_BAD;
                3'd3: cmd_sel = kw_is("ENABLE", 4, kw_len_r) ? CMD_OPER_ENAB : CMD_BAD;
                3'd4: cmd_sel = kw_is("COUNT", 4, kw_len_r) ?
                                (query_r ? CMD_COUNT_Q : CMD_COUNT) : CMD_BAD;
                3'd5: cmd_sel = kw_is("SOURCE", 4, kw_len_r) ? CMD_TRIG_SRC : CMD_BAD;
                3'd6: if (kw_is("CONTINUOUS", 4, kw_len_r)) cmd_sel = CMD_CONT;
                      else if (kw_is("IMMEDIATE", 3, kw_len_r)) cmd_sel = CMD_INIT;
                      else cmd_sel = CMD_BAD;
                default: cmd_sel = CMD_BAD;
            endcase
        end
    end

    // end of a command: separator or terminator with a keyword pending
    logic wr_rx;
    logic term;
    logic exec;
    logic leaf_init;
    // a write lands at the edge that answers it, waitrequest low
    assign wr_rx = avs_write_i && avs_address_i == ADDR_RX && wait_r;
    assign term  = ch == CH_SEMI || ch == CH_LF;
    assign exec  = wr_rx && term && (kw_len_r != 4'h0);
    // bare INIT or ABOR at end executes at level path
    // a common command left under the init level must not start a scan
    assign leaf_init = !is_common_r && path_r != 3'd6 && path_nxt == 3'd6
                       && cmd_sel == CMD_NONE;

    // numeric and special value decode
    // min max def
    logic        num_bad;
    logic [15:0] num_val;
    logic [14:0] cnt_val;
    always_comb begin
        num_val = par_num(num_bad);
        if (par_len_r == 4'h0) cnt_val = COUNT_DEF;
        else if (par_is("MIN")) cnt_val = COUNT_MIN;
        else if (par_is("MAX")) cnt_val = COUNT_MAX;
        else if (par_is("DEF")) cnt_val = COUNT_DEF;
        else cnt_val = num_val[14:0];
    end

    // boolean decode
    // 1/ON true, 0/OFF false
    logic bool_ok;
    logic bool_val;
    assign bool_val = par_is("1") || par_is("ON");
    assign bool_ok  = bool_val || par_is("0") || par_is("OFF");

    // digital bus trigger source name, matched letter by letter
    logic digital_bus_hit;
    assign digital_bus_hit = par_len_r == 4'h4
                             && {up_par[0], up_par[1], up_par[2], up_par[3]} == TXT_DIGITAL_BUS;

    ////////////////////////////////////////////////////////////////////////
    // character capture, levels and message boundaries
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            kw_len_r    <= 4'h0;
            par_len_r   <= 4'h0;
            in_param_r  <= 1'b0;
            is_common_r <= 1'b0;
            query_r     <= 1'b0;
            path_r      <= 3'd0;
            for (int i = 0; i < KW_LEN; i++) begin
                kw_r[i]  <= 8'h00;
                par_r[i] <= 8'h00;
            end
        end else if (wr_rx) begin
            if (term) begin
                kw_len_r    <= 4'h0;
                par_len_r   <= 4'h0;
                in_param_r  <= 1'b0;
                is_common_r <= 1'b0;
                query_r     <= 1'b0;
                if (ch == CH_LF) begin
                    path_r  <= 3'd0;
                end
            end else if (in_param_r) begin
                if (par_len_r < 4'(KW_LEN)) begin
                    par_r[par_len_r] <= ch;
                    par_len_r <= par_len_r + 4'h1;
                end
            end else if (ch == CH_SPACE) begin
                if (kw_len_r != 4'h0) in_param_r <= 1'b1;
            end else if (ch == CH_COLON) begin
                if (kw_len_r == 4'h0) path_r <= 3'd0;
                else path_r <= path_nxt;
                kw_len_r <= 4'h0;
            end else if (ch == CH_STAR && kw_len_r == 4'h0) begin
                is_common_r <= 1'b1;
            end else if (ch == CH_QUERY) begin
                query_r <= 1'b1;
            end else if (kw_len_r < 4'(KW_LEN)) begin
                kw_r[kw_len_r] <= ch;
                kw_len_r <= kw_len_r + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command execution: settings
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            count_r     <= COUNT_DEF;
            cont_r      <= 1'b0;
            trig_src_o  <= SRC_IMM;
            oper_en_r   <= 16'h0000;
            sre_r       <= 8'h00;
            err_r       <= 1'b0;
            resp_r      <= 32'h0000_0000;
        end else begin
            if (avs_write_i && avs_address_i == ADDR_STATUS && wait_r)
                err_r <= 1'b0;
            if (exec) begin
                case (cmd_sel)
                    CMD_SRE: sre_r <= num_val[7:0];
                    CMD_COUNT: if (num_bad && par_len_r != 4'h0 && !par_is("MIN")
                                   && !par_is("MAX") && !par_is("DEF")) err_r <= 1'b1;
                               else count_r <= cnt_val;
                    CMD_COUNT_Q: resp_r <= {17'h0, (par_len_r == 4'h0) ? count_r : cnt_val};
                    CMD_CONT: if (bool_ok) cont_r <= bool_val;
                              else err_r <= 1'b1;
                    CMD_OPER_ENAB: oper_en_r <= num_val;
                    CMD_TRIG_SRC: begin
                        if (par_is("BUS")) trig_src_o <= SRC_BUS;
                        else if (digital_bus_hit) trig_src_o <= SRC_DIGITAL_BUS;
                        else if (par_is("EXT") || par_is("EXTERNAL")) trig_src_o <= SRC_EXT;
                        else if (par_is("HOLD")) trig_src_o <= SRC_HOLD;
                        else if (par_is("IMM") || par_is("IMMEDIATE")) trig_src_o <= SRC_IMM;
                        else err_r <= 1'b1;
                    end
                    CMD_BAD: err_r <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scan run and scan-complete status
    logic do_cls;
    assign do_cls = exec && cmd_sel == CMD_CLS;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            scan_run_o  <= 1'b0;
            bus_start_r <= 1'b0;
        end else if (exec && (cmd_sel == CMD_INIT || leaf_init)) begin
            scan_run_o  <= 1'b1;
            bus_start_r <= 1'b1;
        // abort in bus or hold mode
        end else if (exec && cmd_sel == CMD_ABORT && bus_start_r
                     && (trig_src_o == SRC_BUS || trig_src_o == SRC_HOLD)) begin
            scan_run_o  <= 1'b0;
            bus_start_r <= 1'b0;
        end else if (scan_done_i && !cont_r) begin
            scan_run_o  <= 1'b0;
        end
    end

    // event register: set beats clear
    // bit 8 on cycle end
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) oper_ev_r <= 16'h0000;
        else if (scan_done_i) oper_ev_r <= (do_cls ? 16'h0000 : oper_ev_r) | OPER_SCAN_MASK;
        else if (do_cls) oper_ev_r <= 16'h0000;
    end

    // status byte summary and service request
    // enable mask routes to bit 7
    logic [7:0] stb;
    always_comb begin
        stb = 8'h00;
        stb[STB_OPER_BIT] = |(oper_ev_r & oper_en_r);
        stb[STB_MSS_BIT]  = |(oper_ev_r & oper_en_r) && sre_r[STB_OPER_BIT];
    end
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) srq_o <= 1'b0;
        else srq_o <= |(stb & sre_r) && !do_cls;
    end

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle then answer
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wait_r            <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else begin
            wait_r            <= (avs_read_i || avs_write_i) && !wait_r;
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !wait_r);
            if (avs_read_i && !wait_r) begin
                case (avs_address_i)
                    ADDR_STATUS: avs_readdata_o <= {oper_ev_r, stb, 6'h00, scan_run_o, err_r};
                    ADDR_COUNT:  avs_readdata_o <= resp_r;
                    ADDR_MASKS:  avs_readdata_o <= {oper_en_r, sre_r, 8'h00};
                    default:     avs_readdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_scan_sets_bit: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        scan_done_i |=> oper_ev_r[OPER_SCAN_BIT]) else $error("scan bit not set");
    a_srq_follows: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (scan_done_i && oper_en_r[OPER_SCAN_BIT] && sre_r[STB_OPER_BIT] && !do_cls)
        |=> ##1 srq_o) else $error("srq missing");
    a_mask_gates: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !oper_en_r[OPER_SCAN_BIT] |-> !stb[STB_OPER_BIT]) else $error("bit7 unmasked");
    a_cls_clears: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (do_cls && !scan_done_i) |=> oper_ev_r == 16'h0000) else $error("cls failed");
    a_lf_root: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (wr_rx && ch == CH_LF) |=> path_r == 3'd0 && kw_len_r == 4'h0)
        else $error("no root");
    a_abort_stops: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (exec && cmd_sel == CMD_ABORT && bus_start_r && trig_src_o == SRC_HOLD)
        |=> !scan_run_o) else $error("abort ignored");
    a_space_param: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (wr_rx && ch == CH_SPACE && !in_param_r && kw_len_r != 4'h0)
        |=> in_param_r) else $error("space not delimiter");
    a_bus_answer: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ((avs_read_i || avs_write_i) && avs_waitrequest_o && !wait_r)
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus timing");
    c_scan_done: cover property (@(posedge clk_sys_i) scan_done_i ##1 srq_o);
    c_bad_kw:    cover property (@(posedge clk_sys_i) exec && cmd_sel == CMD_BAD);
    c_count_q:   cover property (@(posedge clk_sys_i) exec && cmd_sel == CMD_COUNT_Q);
endmodule

// ===== tb/scpcp_host_model.sv
// host model: avalon master that hands command text to the parser one character a write
`timescale 1ns/100ps
module scpcp_host_model (
    input  wire logic        clk_sys_i,
    output logic      [3:0]  avs_address_o,
    output logic             avs_read_o,
    output logic             avs_write_o,
    output logic      [31:0] avs_writedata_o,
    input  wire logic [31:0] avs_readdata_i,
    input  wire logic        avs_waitrequest_i
);
    import scpcp_pkg::*;

    // bus idle from time zero
    initial begin
        avs_address_o   = 4'h0;
        avs_read_o      = 1'b0;
        avs_write_o     = 1'b0;
        avs_writedata_o = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one transfer, held until waitrequest is sampled low, released only after that
    task automatic xfer(input logic wr_en, input logic [3:0] addr,
                        input logic [31:0] data, output logic [31:0] q);
        @(posedge clk_sys_i);
        avs_address_o   <= addr;
        avs_write_o     <= wr_en;
        avs_read_o      <= !wr_en;
        avs_writedata_o <= data;
        @(posedge clk_sys_i);
        while (avs_waitrequest_i !== 1'b0) begin
            @(posedge clk_sys_i);
        end
        q = avs_readdata_i;
        avs_read_o      <= 1'b0;
        avs_write_o     <= 1'b0;
        avs_writedata_o <= ~data; // stale data must not look valid
    endtask

    // text as given, one space before a parameter, line end closes it
    task automatic send(input string s);
        logic [31:0] q;
        for (int i = 0; i < s.len(); i++) begin
            xfer(1'b1, ADDR_RX, {24'h0, s[i]}, q);
        end
        xfer(1'b1, ADDR_RX, {24'h0, CH_LF}, q);
    endtask
endmodule

// ===== tb/scpcp_parser_tb_top.sv
// testbench for the text command parser: command lines in, status and outputs checked
`timescale 1ns/100ps
module scpcp_parser_tb_top;
    import scpcp_pkg::*;
    logic        clk_sys_i;
    logic        reset_i;
    logic [3:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        scan_done_i;
    logic        scan_run_o;
    logic        srq_o;
    scpcp_src_t  trig_src_o;
    logic [31:0] q;
    int          n_fail;
    int          checked;
    int          cyc;
    string       srcs [5] = '{"BUS", "bus", "Ext", "HOLD", "imm"};

    scpcp_parser scpcp_parser_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .scan_done_i(scan_done_i),
        .scan_run_o(scan_run_o), .srq_o(srq_o), .trig_src_o(trig_src_o));

    scpcp_host_model scpcp_host_model_i (.clk_sys_i(clk_sys_i),
        .avs_address_o(avs_address_i), .avs_read_o(avs_read_i), .avs_write_o(avs_write_i),
        .avs_writedata_o(avs_writedata_i), .avs_readdata_i(avs_readdata_o),
        .avs_waitrequest_i(avs_waitrequest_o));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counting compare, verdict and helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic rd(input logic [3:0] a);
        scpcp_host_model_i.xfer(1'b0, a, 32'h0, q);
    endtask
    // error flag compare, then cleared by a write to the status place
    task automatic err(input logic e);
        rd(ADDR_STATUS);
        chk({31'h0, q[0]}, {31'h0, e});
        scpcp_host_model_i.xfer(1'b1, ADDR_STATUS, 32'h0, q);
    endtask
    task automatic qry(input string s, input logic [14:0] e);
        scpcp_host_model_i.send(s);
        rd(ADDR_COUNT);
        chk({17'h0, q[14:0]}, {17'h0, e});
    endtask
    // the setting lands at the answering edge: look one edge later
    task automatic src(input scpcp_src_t e);
        @(posedge clk_sys_i);
        chk({29'h0, trig_src_o}, {29'h0, e});
    endtask
    task automatic pulse_done();
        @(posedge clk_sys_i);
        scan_done_i <= 1'b1;
        @(posedge clk_sys_i);
        scan_done_i <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        reset_i = 1'b1;
        scan_done_i = 1'b0;
        n_fail = 0;
        checked = 0;
        cyc = 0;
        // lower-case digital bus source name, first letter added here
        srcs[1] = {"d", srcs[1]};
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        src(SRC_IMM);
        chk({30'h0, srq_o, scan_run_o}, 32'h0);
        qry("ARM:COUN?", 15'h0001);
        for (int i = 0; i < 5; i++) begin
            scpcp_host_model_i.send({"TRIG:SOUR ", srcs[i]});
            src(scpcp_src_t'(i));
        end
        scpcp_host_model_i.send("TRIG:SOUR FOO");
        err(1'b1);
        scpcp_host_model_i.send("TRIG:SOURC BUS");
        err(1'b1);
        src(SRC_IMM);
        qry("arm:count 10", 15'h0001);
        qry("ARM:COUN?", 15'h000A);
        qry("ArM:CoUn 1.23E2;:ARM:COUN?", 15'h007B);
        qry("ARM:COUN +1.5E1;:ARM:COUN?", 15'h000F);
        qry("ARM:COUN MAX;:ARM:COUN?", 15'h7FFF);
        qry("ARM:COUN MIN;:ARM:COUN?", 15'h0001);
        qry("ARM:COUN 9;:ARM:COUN DEF;:ARM:COUN?", 15'h0001);
        qry("ARM:COUN 9;:ARM:COUN;:ARM:COUN?", 15'h0001);
        qry("ARM:COUN? MAX", 15'h7FFF);
        qry("ARM:COUN? MIN", 15'h0001);
        err(1'b0);
        scpcp_host_model_i.send("COUN?");
        err(1'b1);
        qry("*CLS;ARM:COUN 5;:TRIG:SOUR BUS;:ARM:COUN?", 15'h0005);
        src(SRC_BUS);
        scpcp_host_model_i.send("ROUT:SCAN (@100:115)");
        scpcp_host_model_i.send("SCAN (@100:115)");
        scpcp_host_model_i.send("INIT:CONT off;:INIT:CONT 0;:INIT:CONT ON");
        err(1'b0);
        // scan complete without masks: event only
        scpcp_host_model_i.send("*CLS;INIT");
        pulse_done();
        rd(ADDR_STATUS);
        chk({30'h0, q[24], q[15]}, 32'h2);
        chk({31'h0, srq_o}, 32'h0);
        // masks enabled: status byte bit 7 and service request
        scpcp_host_model_i.send("*CLS;STAT:OPER:ENAB 256");
        scpcp_host_model_i.send("*SRE 128");
        scpcp_host_model_i.send("INIT");
        pulse_done();
        rd(ADDR_STATUS);
        chk({30'h0, q[24], q[15]}, 32'h3);
        chk({31'h0, srq_o}, 32'h1);
        scpcp_host_model_i.send("*CLS");
        rd(ADDR_STATUS);
        chk({30'h0, q[24], q[15]}, 32'h0);
        chk({31'h0, srq_o}, 32'h0);
        // abort with bus and hold sources
        for (int i = 0; i < 2; i++) begin
            scpcp_host_model_i.send(i == 0 ? "TRIG:SOUR BUS;:INIT" : "TRIG:SOUR HOLD;:INIT");
            @(posedge clk_sys_i);
            chk({31'h0, scan_run_o}, 32'h1);
            scpcp_host_model_i.send("ABOR");
            rd(ADDR_STATUS);
            chk({31'h0, scan_run_o}, 32'h0);
        end
        // single cycle scan: run ends with the scan-complete pulse
        scpcp_host_model_i.send("INIT:CONT OFF;:INIT");
        @(posedge clk_sys_i);
        chk({31'h0, scan_run_o}, 32'h1);
        pulse_done();
        rd(ADDR_STATUS);
        chk({31'h0, q[1]}, 32'h0);
        end_sim();
    end
endmodule
